// File: sdx_ctrl_properties.sv
// checker: port properties of the sinc/excitation control
`timescale 1ns/1ps
module sdx_ctrl_chk
    import sdx_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_sfr_hit,
    // converter control and timing
    input wire logic i_chop_disable,
    input wire logic i_filter_restart,
    input wire logic [3:0] i_primary_pair,
    input wire logic o_conv_done,
    input wire logic o_result_settled,
    input wire logic [7:0] o_decimation_value,
    // excitation routing
    input wire logic o_exc_a_to_input_seven,
    input wire logic o_exc_a_to_input_eight,
    input wire logic o_exc_b_to_input_seven,
    input wire logic o_exc_b_to_input_eight,
    input wire logic [1:0] o_input_seven_sources,
    input wire logic [1:0] o_input_eight_sources,
    // burnout enables
    input wire logic o_burnout_pair_56,
    input wire logic o_burnout_pair_78
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire exc_wr = i_sfr_wr && i_sfr_addr == SDX_ADDR_EXC;
    // sources expected on input eight, worked out from the written word alone
    wire [1:0] eight_exp = {1'b0, i_sfr_wdata[0] & i_sfr_wdata[2]}
        + {1'b0, i_sfr_wdata[1] & ~i_sfr_wdata[3]};
    property p_a_route;
        exc_wr && i_sfr_wdata[0] && !i_sfr_wdata[2] |=> o_exc_a_to_input_seven;
    endproperty
    a_a_route: assert property (p_a_route) else $error("source a not on input seven");
    property p_b_route;
        exc_wr && i_sfr_wdata[1] && !i_sfr_wdata[3] |=> o_exc_b_to_input_eight;
    endproperty
    a_b_route: assert property (p_b_route) else $error("source b not on input eight");
    property p_off;
        exc_wr && i_sfr_wdata[1:0] == 2'h0 |=> o_input_seven_sources + o_input_eight_sources == 2'h0;
    endproperty
    a_off: assert property (p_off) else $error("disabled source still routed");
    property p_sum;
        exc_wr |=> o_input_eight_sources == $past(eight_exp);
    endproperty
    a_sum: assert property (p_sum) else $error("pin source count wrong");
    property p_burn;
        o_burnout_pair_56 |-> i_primary_pair == 4'hC && !o_burnout_pair_78;
    endproperty
    a_burn: assert property (p_burn) else $error("burnout on wrong pair");
    property p_mask;
        i_sfr_rd && i_sfr_addr == SDX_ADDR_EXC |=> o_sfr_hit && (o_sfr_rdata & 8'hB0) == 8'h00;
    endproperty
    a_mask: assert property (p_mask) else $error("unused excitation bits read back");
    property p_word;
        i_sfr_wr && i_sfr_addr == SDX_ADDR_DECIM |=> o_decimation_value == $past(i_sfr_wdata);
    endproperty
    a_word: assert property (p_word) else $error("decimation word not kept");
    property p_pulse;
        o_conv_done |=> !o_conv_done;
    endproperty
    a_pulse: assert property (p_pulse) else $error("conversion pulse too long");
    property p_clear;
        $changed(i_chop_disable) || i_filter_restart |-> ##2 !o_result_settled;
    endproperty
    a_clear: assert property (p_clear) else $error("settled kept after restart");
    property p_keep;
        exc_wr && o_result_settled && !i_filter_restart && $stable(i_chop_disable)
            |=> o_result_settled;
    endproperty
    a_keep: assert property (p_keep) else $error("excitation write restarted");
    c_done: cover property (o_conv_done);
    c_settled: cover property ($rose(o_result_settled));
    c_dual: cover property (o_input_eight_sources == 2'h2);
endmodule // sdx_ctrl_chk

bind sdx_sinc_exc_ctrl sdx_ctrl_chk chk_u (.*);

// File: sdx_pkg.sv
// package: register map, field positions and timing constants for the sinc/excitation control
package sdx_pkg;
    // special-function register addresses
    localparam logic [7:0] SDX_ADDR_DECIM = 8'hD4;
    localparam logic [7:0] SDX_ADDR_EXC = 8'hD5;
    // reset values
    localparam logic [7:0] SDX_DECIM_RST = 8'h45;
    localparam logic [7:0] SDX_EXC_RST = 8'h00;
    // decimation limits
    localparam logic [7:0] SDX_DECIM_MIN_CHOP = 8'h0D;
    localparam logic [7:0] SDX_DECIM_MAX = 8'hFF;
    // excitation control fields
    localparam int SDX_EXC_A_EN = 0;
    localparam int SDX_EXC_B_EN = 1;
    localparam int SDX_EXC_A_SEL = 2;
    localparam int SDX_EXC_B_SEL = 3;
    localparam int SDX_BURNOUT_EN = 6;
    localparam logic [7:0] SDX_EXC_IMPL_MASK = 8'h4F;
    // base modulator rate and system clock
    localparam int SDX_BASE_HZ = 32768;
    localparam int SDX_MCLK_HZ = 40000000;
    // system clocks per base tick, rounded down (shortest time)
    localparam int SDX_BASE_DIV = SDX_MCLK_HZ / SDX_BASE_HZ;
    localparam logic [10:0] SDX_BASE_DIV_M1 = 11'(SDX_BASE_DIV - 1);
    // base ticks per decimation unit: 8 chop off, 3 x 8 chop on
    localparam logic [4:0] SDX_TICKS_CHOP_OFF = 5'h08;
    localparam logic [4:0] SDX_TICKS_CHOP_ON = 5'h18;
    // conversion periods before the first settled result
    localparam logic [1:0] SDX_SETTLE_CHOP_ON = 2'h2;
    localparam logic [1:0] SDX_SETTLE_CHOP_OFF = 2'h3;
endpackage

// File: sdx_sinc_exc_ctrl.sv
// sinc decimation word and excitation current control registers with conversion timer
//
// Contract
// - conversion rate is 32.768 kHz over 24*word with chop, 8*word without.
// - with chop on, decimation words below 13 act as 13.
// - calibration uses the programmed decimation word, never forcing 255.
// - chop-control bit 0 enables chopping, 1 disables it, changing rate.
// - bit 6 enables burnout currents only on input pairs five/six, seven/eight.
// - bit 3 routes source b to input eight when 0, seven when 1.
// - bit 2 routes source a to input seven when 0, eight when 1.
// - bit 1 enables source b, bit 0 source a; zero disables.
// - excitation bits 7, 5, 4 have no function; writes ignored.
// - excitation writes act at once, never restarting a conversion.
// - both sources may drive one pin, summing to 400 uA.
`timescale 1ns/1ps
module sdx_sinc_exc_ctrl
    import sdx_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // special-function register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // converter control
    input wire logic i_chop_disable,
    input wire logic i_calibrating,
    input wire logic i_filter_restart,
    input wire logic [3:0] i_primary_pair,
    // conversion timing
    output logic o_conv_done,
    output logic o_result_settled,
    output logic [7:0] o_decimation_value,
    // excitation source a routing
    output logic o_exc_a_to_input_seven,
    output logic o_exc_a_to_input_eight,
    // excitation source b routing
    output logic o_exc_b_to_input_seven,
    output logic o_exc_b_to_input_eight,
    // combined source count per pin, 2 means 400 uA
    output logic [1:0] o_input_seven_sources,
    output logic [1:0] o_input_eight_sources,
    // burnout current enables per input pair
    output logic o_burnout_pair_56,
    output logic o_burnout_pair_78
);
    // primary pair codes: 4'hC is five/six, 4'hD is seven/eight
    localparam logic [3:0] SDX_PAIR_56 = 4'hC;
    localparam logic [3:0] SDX_PAIR_78 = 4'hD;

    typedef struct packed {
        logic [7:0] decim;
        logic [7:0] exc;
        logic [4:0] tick_cnt;
        logic [7:0] word_cnt;
        logic [1:0] settle_cnt;
        logic settled;
        logic done;
        logic chop_dis;
        logic [7:0] rdata;
        logic hit;
    } sdx_state_s;

    sdx_state_s st_q;
    sdx_state_s st_d;
    logic base_tick;
    logic [7:0] eff_word;
    logic [4:0] ticks_per_unit;
    logic [1:0] settle_need;
    logic sel_decim;
    logic sel_exc;
    logic unit_end;
    logic period_end;
    logic chop_changed;
    logic restart;
    logic on_pair_56;
    logic on_pair_78;
    logic [1:0] src_on;
    logic [1:0] src_to_seven;
    logic [1:0] src_to_eight;

    sdx_tick_div u_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .o_tick(base_tick)
    );

    // one decoder serves reads and writes, so both always see the same map
    always_comb begin
        sel_decim = 1'b0;
        sel_exc = 1'b0;
        if (i_sfr_addr == SDX_ADDR_DECIM) begin
            sel_decim = 1'b1;
        end else if (i_sfr_addr == SDX_ADDR_EXC) begin
            sel_exc = 1'b1;
        end
    end

    // calibration deliberately has no override of the word
    always_comb begin
        eff_word = st_q.decim;
        if (!i_chop_disable && st_q.decim < SDX_DECIM_MIN_CHOP) begin
            eff_word = SDX_DECIM_MIN_CHOP;
        end
        // a zero word with chop off would stall the timer; treat as one unit
        if (eff_word == 8'h00) begin
            eff_word = 8'h01;
        end
    end

    assign ticks_per_unit = i_chop_disable ? SDX_TICKS_CHOP_OFF : SDX_TICKS_CHOP_ON;
    assign settle_need = i_chop_disable ? SDX_SETTLE_CHOP_OFF : SDX_SETTLE_CHOP_ON;
    // a word rewritten mid-period is compared at the next unit end, so no restart is needed
    assign unit_end = base_tick && (st_q.tick_cnt == ticks_per_unit - 5'h01);
    assign period_end = unit_end && (st_q.word_cnt >= eff_word - 8'h01);

    // a chop change alters the rate, so the period in flight is thrown away
    assign chop_changed = st_q.chop_dis != i_chop_disable;
    assign restart = i_filter_restart || chop_changed;

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.hit = 1'b0;
        st_d.rdata = 8'h00;
        st_d.chop_dis = i_chop_disable;
        // register writes; excitation writes never touch the timer
        if (i_sfr_wr) begin
            if (sel_decim) begin
                st_d.decim = i_sfr_wdata;
            end else if (sel_exc) begin
                st_d.exc = i_sfr_wdata & SDX_EXC_IMPL_MASK;
            end
        end
        if (i_sfr_rd) begin
            if (sel_decim) begin
                st_d.rdata = st_q.decim;
                st_d.hit = 1'b1;
            end else if (sel_exc) begin
                st_d.rdata = st_q.exc;
                st_d.hit = 1'b1;
            end else begin
                st_d.rdata = 8'h00;
            end
        end
        // conversion period: eff_word units of ticks_per_unit base ticks
        if (restart) begin
            st_d.tick_cnt = 5'h00;
            st_d.word_cnt = 8'h00;
            st_d.settle_cnt = 2'h0;
            st_d.settled = 1'b0;
        end else if (unit_end) begin
            st_d.tick_cnt = 5'h00;
            if (period_end) begin
                st_d.word_cnt = 8'h00;
                st_d.done = 1'b1;
                if (!st_q.settled) begin
                    if (st_q.settle_cnt + 2'h1 >= settle_need) begin
                        st_d.settled = 1'b1;
                    end else begin
                        st_d.settle_cnt = st_q.settle_cnt + 2'h1;
                    end
                end
            end else begin
                st_d.word_cnt = st_q.word_cnt + 8'h01;
            end
        end else if (base_tick) begin
            st_d.tick_cnt = st_q.tick_cnt + 5'h01;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
            st_q.decim <= SDX_DECIM_RST;
            st_q.exc <= SDX_EXC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sfr_rdata = st_q.rdata;
    assign o_sfr_hit = st_q.hit;
    assign o_conv_done = st_q.done;
    assign o_result_settled = st_q.settled;
    assign o_decimation_value = st_q.decim;

    // routing follows the register directly, so changes act at once
    // source a reads its select high as input eight, source b reads it high as input seven
    generate
        for (genvar s = 0; s < 2; s++) begin : g_src
            localparam int EN_BIT = (s == 0) ? SDX_EXC_A_EN : SDX_EXC_B_EN;
            localparam int SEL_BIT = (s == 0) ? SDX_EXC_A_SEL : SDX_EXC_B_SEL;
            localparam logic EIGHT_LVL = (s == 0) ? 1'b1 : 1'b0;
            assign src_on[s] = st_q.exc[EN_BIT];
            assign src_to_eight[s] = src_on[s] & (st_q.exc[SEL_BIT] == EIGHT_LVL);
            assign src_to_seven[s] = src_on[s] & (st_q.exc[SEL_BIT] != EIGHT_LVL);
        end
    endgenerate

    assign o_exc_a_to_input_seven = src_to_seven[0];
    assign o_exc_a_to_input_eight = src_to_eight[0];
    assign o_exc_b_to_input_seven = src_to_seven[1];
    assign o_exc_b_to_input_eight = src_to_eight[1];
    // both sources on one pin is legal and their currents add
    assign o_input_seven_sources = {1'b0, o_exc_a_to_input_seven}
        + {1'b0, o_exc_b_to_input_seven};
    assign o_input_eight_sources = {1'b0, o_exc_a_to_input_eight}
        + {1'b0, o_exc_b_to_input_eight};
    // burnout current exists only on the two supported pairs
    assign on_pair_56 = (i_primary_pair == SDX_PAIR_56);
    assign on_pair_78 = (i_primary_pair == SDX_PAIR_78);
    assign o_burnout_pair_56 = st_q.exc[SDX_BURNOUT_EN] & on_pair_56;
    assign o_burnout_pair_78 = st_q.exc[SDX_BURNOUT_EN] & on_pair_78;
endmodule // sdx_sinc_exc_ctrl

// File: sdx_tick_div.sv
// base-rate divider: one-cycle enable at the 32.768 kHz modulator rate
`timescale 1ns/1ps
module sdx_tick_div
    import sdx_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // base-rate enable
    output logic o_tick
);
    typedef struct packed {
        logic [10:0] cnt;
        logic tick;
    } sdx_div_s;

    sdx_div_s st_q;
    sdx_div_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == SDX_BASE_DIV_M1) begin
            st_d.cnt = 11'h000;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 11'h001;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_tick = st_q.tick;
endmodule // sdx_tick_div

// File: testbench.sv
// testbench: register and timing checks for the sinc/excitation control
`timescale 1ns/1ps
module testbench;
    import sdx_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_chop_disable = 1'b1;
    logic i_calibrating = 1'b1, i_filter_restart = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, o_decimation_value, v;
    logic [3:0] i_primary_pair = 4'h0;
    logic [1:0] o_input_seven_sources, o_input_eight_sources;
    logic o_sfr_hit, o_conv_done, o_result_settled, o_burnout_pair_56, o_burnout_pair_78;
    logic o_exc_a_to_input_seven, o_exc_a_to_input_eight, o_exc_b_to_input_seven;
    logic o_exc_b_to_input_eight;
    int miscompares = 0, checks_done = 0, n;
    wire [7:0] route = {o_input_seven_sources, o_input_eight_sources, o_exc_a_to_input_seven,
        o_exc_a_to_input_eight, o_exc_b_to_input_seven, o_exc_b_to_input_eight};
    sdx_sinc_exc_ctrl dut_u (.*);
    always #12.5 i_mclk = ~i_mclk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        {i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {a, d, 1'b1};
        @(negedge i_mclk);
        i_sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(negedge i_mclk);
        {i_sfr_addr, i_sfr_rd} = {a, 1'b1};
        @(negedge i_mclk);
        i_sfr_rd = 1'b0;
        chk({o_sfr_hit, o_sfr_rdata}, {hit, exp});
    endtask
    // bounded wait; counts falling edges up to the conversion pulse
    task automatic wait_done(output int cyc);
        cyc = 0;
        do begin
            @(negedge i_mclk);
            cyc++;
        end while (o_conv_done !== 1'b1 && cyc < 12000);
        if (o_conv_done !== 1'b1) begin
            miscompares++;
            tally_and_finish;
        end
    endtask
    function automatic logic [7:0] exp_route(input logic [7:0] w);
        logic a7, a8, b7, b8;
        {a7, a8, b7, b8} = {w[0] & ~w[2], w[0] & w[2], w[1] & w[3], w[1] & ~w[3]};
        return {2'(a7) + 2'(b7), 2'(a8) + 2'(b8), a7, a8, b7, b8};
    endfunction
    initial begin
        repeat (4) @(negedge i_mclk);
        i_rst = 1'b0;
        rd(SDX_ADDR_DECIM, SDX_DECIM_RST, 1'b1);
        rd(SDX_ADDR_EXC, SDX_EXC_RST, 1'b1);
        rd(8'hD6, 8'h00, 1'b0);
        for (int k = 0; k < 16; k++) begin
            v = 8'hB0 | 8'(k);
            wr(SDX_ADDR_EXC, v);
            chk(route, exp_route(v));
            rd(SDX_ADDR_EXC, v & 8'h0F, 1'b1);
        end
        wr(SDX_ADDR_EXC, 8'h40);
        for (int p = 11; p < 15; p++) begin
            i_primary_pair = 4'(p);
            @(negedge i_mclk);
            chk({o_burnout_pair_56, o_burnout_pair_78}, {p == 12, p == 13});
        end
        // calibration held on: the word must stay as written
        wr(SDX_ADDR_DECIM, 8'h01);
        chk(o_decimation_value, 8'h01);
        i_filter_restart = 1'b1;
        @(negedge i_mclk);
        i_filter_restart = 1'b0;
        wait_done(n);
        wait_done(n);
        chk(16'(n), 16'(8 * SDX_BASE_DIV));
        chk(o_result_settled, 1'b0);
        wr(SDX_ADDR_EXC, 8'h0F);
        wait_done(n);
        chk(16'(n), 16'(8 * SDX_BASE_DIV - 2));
        @(negedge i_mclk);
        chk(o_result_settled, 1'b1);
        wr(SDX_ADDR_EXC, 8'h03);
        chk(o_result_settled, 1'b1);
        i_chop_disable = 1'b0;
        repeat (3) @(negedge i_mclk);
        chk(o_result_settled, 1'b0);
        tally_and_finish;
    end
endmodule // testbench
